// ==== hdl/hrc_ctrl.sv ====
// Histogram range/autorange/enable and triggered capture control with Avalon-MM slave
// Function
// - A requested highest current picks the smallest histogram range that can measure it.
// - The minimum keyword picks the lowest range, the maximum keyword the highest, the default.
// - A range read returns the full scale of the range in use, not the requested value.
// - Autoranging never enters the lowest 10 uA range; only a manual selection reaches it.
// - With autoranging on, the manual range is ignored and ranging follows the signal.
// - Autoranging is off after reset and reads back as 0 for off and 1 for on.
// - The histogram function is per channel, off after reset, read back as 0 or 1.
// - The trigger offset is held between minus one less than the depth and 2,000,000,000.
// - A positive offset waits that many sample periods after the trigger before storing.
// - A negative offset keeps that many pre-trigger samples at the start of the record.
// - The depth limit is 512K, 256K, 128K or 64K points for one to four parameters.
// - Up to eight parameters, voltage and current of four outputs, may be selected.
// - Depth resets to 1024 points, or 4883 on the source-measure variant, minimum one.
// - Range, autorange, histogram, depth and offset are held and read back per channel; the parameter mask and capture channel are global.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "hrc_regs.svh"

module hrc_ctrl
  import hrc_pkg::*;
#(
  parameter int NCH         = 4,
  parameter int MEM_DEPTH   = 524288,
  parameter bit SMU_VARIANT = 1'b0
) (
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire logic [7:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic [NCH-1:0][31:0]      curMag,
  input  wire logic [NCH-1:0]            curValid,
  input  wire logic                      smpValid,
  input  wire logic [15:0]               smpData,
  input  wire logic                      trigIn,
  output hrc_chan_s [NCH-1:0]            chanCfg,
  output logic                           capBusy,
  output logic                           capDone
);

  localparam int AW = $clog2(MEM_DEPTH);
  localparam logic [19:0] RST_DEPTH = SMU_VARIANT ? `HRC_RST_DEPTH_SMU : `HRC_RST_DEPTH;

  // Smallest range whose full scale covers the value
  function automatic hrc_range_t pickRange(input logic [31:0] ua);
    if (ua <= `HRC_FS0_UA) begin
      pickRange = 2'd0;
    end else if (ua <= `HRC_FS1_UA) begin
      pickRange = 2'd1;
    end else if (ua <= `HRC_FS2_UA) begin
      pickRange = 2'd2;
    end else begin
      pickRange = `HRC_RANGE_MAX;
    end
  endfunction

  // Full scale of a range code
  function automatic logic [31:0] fullScale(input hrc_range_t c);
    case (c)
      2'd0:    fullScale = `HRC_FS0_UA;
      2'd1:    fullScale = `HRC_FS1_UA;
      2'd2:    fullScale = `HRC_FS2_UA;
      default: fullScale = `HRC_FS3_UA;
    endcase
  endfunction

  // Bus decode
  wire        chanHit  = ~avs_address[7];
  wire [1:0]  chanSel  = avs_address[6:5];
  wire [4:0]  subOff   = avs_address[4:0];
  wire        ctlWr    = avs_write && (avs_address == `HRC_OFF_CAPCTL);
  wire        rdAddrWr = avs_write && (avs_address == `HRC_OFF_RDADDR);

  // Global capture settings
  logic [7:0]     paramMask_reg;
  logic [1:0]     capCh_reg;
  logic           rdPend_reg;
  logic [31:0]    readdata_reg;
  logic [AW-1:0]  rdIdx_reg;

  // Parameter count sets the depth ceiling
  logic [3:0] paramCnt;
  always_comb begin
    paramCnt = 4'd0;
    for (int i = 0; i < 8; i++) begin
      paramCnt = paramCnt + {3'd0, paramMask_reg[i]};
    end
  end
  wire [1:0]  depthShift = (paramCnt <= 4'd1) ? 2'd0 :
                           (paramCnt >= 4'd4) ? 2'd3 : paramCnt[1:0] - 2'd1;
  wire [19:0] depthMax   = `HRC_DEPTH_MAX_1P >> depthShift;

  logic [NCH-1:0][31:0] chRd;
  logic [NCH-1:0][19:0] depthArr;
  logic [NCH-1:0][31:0] offArr;

  // Per-channel settings
  for (genvar g = 0; g < NCH; g++) begin : gCh
    hrc_range_t         manRange_reg;
    hrc_range_t         effRange_reg;
    logic               autoEn_reg;
    logic               histEn_reg;
    logic [19:0]        depth_reg;
    logic signed [31:0] offset_reg;

    wire selCh = chanHit && (chanSel == 2'(g));
    wire wrEn  = avs_write && selCh;

    // Keyword or value to range code
    wire hrc_range_t reqRange = avs_writedata[`HRC_RNG_KW_BIT] ?
      (avs_writedata[`HRC_RNG_MAX_BIT] ? `HRC_RANGE_MAX : `HRC_RANGE_MIN) :
      pickRange({2'b00, avs_writedata[`HRC_RNG_VAL_W-1:0]});

    // Autorange choice, floored above the lowest range
    wire hrc_range_t autoRaw  = pickRange(curMag[g]);
    wire hrc_range_t autoPick = (autoRaw < `HRC_RANGE_AUTO_LO) ? `HRC_RANGE_AUTO_LO : autoRaw;

    // Depth clamped to 1..limit
    wire [19:0] depthNew = (avs_writedata > {12'd0, depthMax}) ? depthMax :
                           (avs_writedata == 32'h0) ? 20'h00001 : avs_writedata[19:0];

    // Offset clamped between -(depth-1) and the upper limit
    wire signed [31:0] offLo  = 32'sd1 - $signed({12'd0, depth_reg});
    wire signed [31:0] wdS    = $signed(avs_writedata);
    wire signed [31:0] offNew = (wdS < offLo) ? offLo :
                                (wdS > `HRC_OFFSET_MAX) ? `HRC_OFFSET_MAX : wdS;

    // Setting registers
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        manRange_reg <= `HRC_RANGE_MAX;
        autoEn_reg   <= 1'b0;
        histEn_reg   <= 1'b0;
        depth_reg    <= RST_DEPTH;
        offset_reg   <= `HRC_RST_OFFSET;
      end else if (wrEn) begin
        if (subOff == `HRC_OFF_RANGE) manRange_reg <= reqRange;
        if (subOff == `HRC_OFF_AUTO) autoEn_reg <= avs_writedata[0];
        if (subOff == `HRC_OFF_HIST) histEn_reg <= avs_writedata[0];
        if (subOff == `HRC_OFF_DEPTH) depth_reg <= depthNew;
        if (subOff == `HRC_OFF_OFFSET) offset_reg <= offNew;
      end
    end

    // Range in use: manual copy, or tracking the signal while autoranging
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        effRange_reg <= `HRC_RANGE_MAX;
      end else if (!autoEn_reg) begin
        effRange_reg <= manRange_reg;
      end else if (curValid[g]) begin
        effRange_reg <= autoPick;
      end else if (effRange_reg < `HRC_RANGE_AUTO_LO) begin
        effRange_reg <= `HRC_RANGE_AUTO_LO;
      end
    end

    // Channel read mux
    assign chRd[g] = (subOff == `HRC_OFF_RANGE)  ? fullScale(effRange_reg) :
                     (subOff == `HRC_OFF_AUTO)   ? {31'd0, autoEn_reg} :
                     (subOff == `HRC_OFF_HIST)   ? {31'd0, histEn_reg} :
                     (subOff == `HRC_OFF_DEPTH)  ? {12'd0, depth_reg} :
                     (subOff == `HRC_OFF_OFFSET) ? offset_reg :
                     (subOff == `HRC_OFF_CHSTAT) ? {28'd0, manRange_reg, effRange_reg} :
                     32'h0;
    assign depthArr[g] = depth_reg;
    assign offArr[g]   = offset_reg;
    assign chanCfg[g]  = '{histEn: histEn_reg, autoEn: autoEn_reg, rangeCode: effRange_reg};
  end

  // Capture sequencer
  hrc_cap_e       state_reg;
  hrc_cap_e       state_next;
  logic [AW-1:0]  wrPtr_reg;
  logic [AW-1:0]  startPtr_reg;
  logic [AW-1:0]  startPtr_next;
  logic [19:0]    preCnt_reg;
  logic [31:0]    delayCnt_reg;
  logic [31:0]    delayCnt_next;
  logic [19:0]    storeCnt_reg;
  logic [19:0]    storeCnt_next;
  logic [15:0]    mem [MEM_DEPTH];

  wire [19:0]         capDepth = depthArr[capCh_reg];
  wire signed [31:0]  capOff   = $signed(offArr[capCh_reg]);
  wire                armWr    = ctlWr && avs_writedata[`HRC_CTL_ARM_BIT];
  wire                stopWr   = ctlWr && !avs_writedata[`HRC_CTL_ARM_BIT];
  wire                memWe    = smpValid && (state_reg == CAP_PRE || state_reg == CAP_STORE);
  wire [19:0]         preAvail = (smpValid && preCnt_reg < 20'(MEM_DEPTH)) ?
                                 preCnt_reg + 20'd1 : preCnt_reg;
  wire [19:0]         preWant  = capOff[31] ? 20'(-capOff) : 20'd0;
  wire [19:0]         preUse   = (preWant < preAvail) ? preWant : preAvail;
  wire [AW-1:0]       wrPtrAdv = wrPtr_reg + AW'(smpValid);

  // Next-state logic
  always_comb begin
    state_next    = state_reg;
    startPtr_next = startPtr_reg;
    delayCnt_next = delayCnt_reg;
    storeCnt_next = storeCnt_reg;
    case (state_reg)
      CAP_IDLE, CAP_DONE: begin
        if (armWr) state_next = CAP_PRE;
      end
      CAP_PRE: begin
        if (trigIn && capOff > 32'sd0) begin
          state_next    = CAP_DELAY;
          delayCnt_next = capOff;
        end else if (trigIn) begin
          startPtr_next = wrPtrAdv - AW'(preUse);
          storeCnt_next = capDepth - preUse;
          state_next    = (capDepth == preUse) ? CAP_DONE : CAP_STORE;
        end
      end
      CAP_DELAY: begin
        if (smpValid) begin
          delayCnt_next = delayCnt_reg - 32'd1;
          if (delayCnt_reg == 32'd1) begin
            state_next    = CAP_STORE;
            startPtr_next = wrPtr_reg;
            storeCnt_next = capDepth;
          end
        end
      end
      CAP_STORE: begin
        if (smpValid) begin
          storeCnt_next = storeCnt_reg - 20'd1;
          if (storeCnt_reg == 20'd1) state_next = CAP_DONE;
        end
      end
      default: state_next = CAP_IDLE;
    endcase
    if (stopWr) state_next = CAP_IDLE;
  end

  // Sequencer registers; pre-trigger fill counts held samples
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= CAP_IDLE;
      wrPtr_reg    <= '0;
      startPtr_reg <= '0;
      preCnt_reg   <= 20'd0;
      delayCnt_reg <= 32'd0;
      storeCnt_reg <= 20'd0;
    end else begin
      state_reg    <= state_next;
      startPtr_reg <= startPtr_next;
      delayCnt_reg <= delayCnt_next;
      storeCnt_reg <= storeCnt_next;
      if (memWe) wrPtr_reg <= wrPtr_reg + AW'(1);
      if (armWr) preCnt_reg <= 20'd0;
      else if (state_reg == CAP_PRE) preCnt_reg <= preAvail;
    end
  end

  // Circular sample store
  always_ff @(posedge core_clk) begin
    if (memWe) mem[wrPtr_reg] <= smpData;
  end

  // Global control, readback index and read data
  wire        rdTake   = avs_read && !rdPend_reg;
  wire [31:0] globRd   = (avs_address == `HRC_OFF_CAPCTL) ?
                           {16'd0, paramMask_reg, 5'd0, capCh_reg, capBusy} :
                         (avs_address == `HRC_OFF_CAPSTAT) ? {27'd0, state_reg} :
                         (avs_address == `HRC_OFF_RDADDR) ? 32'(rdIdx_reg) :
                         32'h0;
  wire        memRdSel = (avs_address == `HRC_OFF_RDDATA);
  wire [31:0] busRd    = chanHit ? chRd[chanSel] : globRd;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      paramMask_reg <= `HRC_RST_MASK;
      capCh_reg     <= 2'd0;
      rdPend_reg    <= 1'b0;
      readdata_reg  <= 32'h0;
      rdIdx_reg     <= '0;
    end else begin
      rdPend_reg <= rdTake;
      if (ctlWr) begin
        capCh_reg     <= avs_writedata[`HRC_CTL_CH_LSB +: 2];
        paramMask_reg <= avs_writedata[`HRC_CTL_MASK_LSB +: 8];
      end
      if (rdAddrWr) rdIdx_reg <= avs_writedata[AW-1:0];
      else if (rdTake && memRdSel) rdIdx_reg <= rdIdx_reg + AW'(1);
      if (rdTake) begin
        readdata_reg <= memRdSel ? {16'd0, mem[startPtr_reg + rdIdx_reg]} : busRd;
      end
    end
  end

  // Bus and status outputs
  assign avs_readdata    = readdata_reg;
  assign avs_waitrequest = rdTake;
  assign capBusy = (state_reg == CAP_PRE) || (state_reg == CAP_DELAY) || (state_reg == CAP_STORE);
  assign capDone = (state_reg == CAP_DONE);

endmodule

// ==== hdl/hrc_regs.svh ====
// Register offsets, field positions, reset values and limits of the histogram/capture control
`ifndef HRC_REGS_SVH
`define HRC_REGS_SVH

// Per-channel block: byte offset within a 32-byte channel window
`define HRC_CH_STRIDE      8'h20
`define HRC_OFF_RANGE      5'h00
`define HRC_OFF_AUTO       5'h04
`define HRC_OFF_HIST       5'h08
`define HRC_OFF_DEPTH      5'h0c
`define HRC_OFF_OFFSET     5'h10
`define HRC_OFF_CHSTAT     5'h14

// Global capture block
`define HRC_OFF_CAPCTL     8'h80
`define HRC_OFF_CAPSTAT    8'h84
`define HRC_OFF_RDADDR     8'h88
`define HRC_OFF_RDDATA     8'h8c

// Range write word fields
`define HRC_RNG_KW_BIT     31
`define HRC_RNG_MAX_BIT    30
`define HRC_RNG_VAL_W      30

// Capture control fields
`define HRC_CTL_ARM_BIT    0
`define HRC_CTL_CH_LSB     1
`define HRC_CTL_MASK_LSB   8

// Range codes and full scales in microamperes
`define HRC_RANGE_MIN      2'd0
`define HRC_RANGE_AUTO_LO  2'd1
`define HRC_RANGE_MAX      2'd3
`define HRC_FS0_UA         32'h0000_000a
`define HRC_FS1_UA         32'h0000_03e8
`define HRC_FS2_UA         32'h0001_86a0
`define HRC_FS3_UA         32'h007a_1200

// Reset values and limits
`define HRC_RST_DEPTH      20'h00400
`define HRC_RST_DEPTH_SMU  20'h01313
`define HRC_RST_OFFSET     32'h0000_0000
`define HRC_RST_MASK       8'h01
`define HRC_DEPTH_MAX_1P   20'h80000
`define HRC_OFFSET_MAX     32'sh7735_9400

`endif

// ==== hdl/hrc_pkg.sv ====
// Types shared by the histogram range and capture control
package hrc_pkg;

  typedef logic [1:0] hrc_range_t;

  // Per-channel configuration seen by the measurement path
  typedef struct packed {
    logic       histEn;
    logic       autoEn;
    hrc_range_t rangeCode;
  } hrc_chan_s;

  // Capture sequencer states
  typedef enum logic [4:0] {
    CAP_IDLE  = 5'b00001,
    CAP_PRE   = 5'b00010,
    CAP_DELAY = 5'b00100,
    CAP_STORE = 5'b01000,
    CAP_DONE  = 5'b10000
  } hrc_cap_e;

endpackage

// ==== tb/hrc_ctrl_checker.sv ====
// Port checker for the histogram range and capture control
`timescale 1ns/10ps
`include "hrc_regs.svh"
module hrc_ctrl_checker
  import hrc_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic                 core_clk,
  input wire logic                 arst_n,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic [NCH-1:0][31:0] curMag,
  input wire logic [NCH-1:0]       curValid,
  input wire logic                 trigIn,
  input wire hrc_chan_s [NCH-1:0]  chanCfg,
  input wire logic                 capBusy,
  input wire logic                 capDone
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // Bus timing, readback hold, reset defaults and capture sequencing
  AST_WR_NOWAIT: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
  AST_RD_ONEWAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait not one cycle");
  AST_RD_HOLD: assert property (!avs_read |=> $stable(avs_readdata)) else $error("rdata moved");
  AST_RST_CFG: assert property ($rose(arst_n) |-> chanCfg == {NCH{4'h3}})
    else $error("reset config wrong");
  AST_TRIG_IGN: assert property (trigIn && !capBusy && !avs_write |=> !capBusy)
    else $error("trigger outside pre taken");
  AST_DONE_HOLD: assert property (capDone && !avs_write |=> capDone) else $error("done dropped");
  AST_DONE_CAUSE: assert property ($rose(capDone) |-> $past(capBusy))
    else $error("done without capture");

  // Autoranging per channel
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    AST_AUTO_NOMIN: assert property (chanCfg[c].autoEn && $past(chanCfg[c].autoEn)
      |-> chanCfg[c].rangeCode != `HRC_RANGE_MIN) else $error("auto entered lowest");
    AST_AUTO_LOW: assert property (curValid[c] && chanCfg[c].autoEn && !avs_write
      && curMag[c] <= `HRC_FS1_UA |=> chanCfg[c].rangeCode == `HRC_RANGE_AUTO_LO)
      else $error("auto low range wrong");
    AST_AUTO_HIGH: assert property (curValid[c] && chanCfg[c].autoEn && !avs_write
      && curMag[c] > `HRC_FS2_UA |=> chanCfg[c].rangeCode == `HRC_RANGE_MAX)
      else $error("auto high range wrong");
  end
endmodule

bind hrc_ctrl hrc_ctrl_checker #(.NCH(NCH)) u_chk (.core_clk(core_clk), .arst_n(arst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .curMag(curMag), .curValid(curValid), .trigIn(trigIn),
  .chanCfg(chanCfg), .capBusy(capBusy), .capDone(capDone));

// ==== tb/hrc_host_model.sv ====
// Avalon-MM host model issuing register commands
`timescale 1ns/10ps
module hrc_host_model (
  input  wire logic        core_clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  // Idle bus at time zero
  initial begin
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
  end

  // One transfer, held until waitrequest is seen low, then released
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    avs_address   <= a;
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_address   <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the histogram range and capture control
`timescale 1ns/10ps
`include "hrc_regs.svh"
module testbench;
  import hrc_pkg::*;
  logic                  core_clk;
  logic                  arst_n;
  logic       [7:0]      avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic       [31:0]     avs_writedata;
  logic       [31:0]     avs_readdata;
  logic                  avs_waitrequest;
  logic       [3:0][31:0] curMag;
  logic       [3:0]      curValid;
  logic                  smpValid;
  logic       [15:0]     smpData;
  logic                  trigIn;
  hrc_chan_s  [3:0]      chanCfg;
  logic                  capBusy;
  logic                  capDone;
  logic       [31:0]     q;
  logic       [15:0]     s [8];
  logic       [31:0]     mv [4];
  int                    num_errors;
  int                    n_compared;
  int                    c;
  int                    v;
  int                    dp [3] = '{2, 4, 3};
  int                    of [3] = '{2, -2, 0};
  int                    np [3] = '{1, 3, 2};

  hrc_ctrl #(.NCH(4), .MEM_DEPTH(1024), .SMU_VARIANT(1'b0)) u_dut (.core_clk(core_clk),
    .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .curMag(curMag), .curValid(curValid),
    .smpValid(smpValid), .smpData(smpData), .trigIn(trigIn), .chanCfg(chanCfg),
    .capBusy(capBusy), .capDone(capDone));
  hrc_host_model u_host (.core_clk(core_clk), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata));

  // 200 MHz clock
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  // Compare, bus helpers, expected full scale
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    u_host.xfer(1'b1, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  function automatic logic [7:0] ad(input int ch, input logic [4:0] o);
    return 8'(ch) * `HRC_CH_STRIDE + {3'b000, o};
  endfunction
  function automatic logic [31:0] fs(input logic [31:0] m);
    if (m <= `HRC_FS0_UA) return `HRC_FS0_UA;
    if (m <= `HRC_FS1_UA) return `HRC_FS1_UA;
    if (m <= `HRC_FS2_UA) return `HRC_FS2_UA;
    return `HRC_FS3_UA;
  endfunction
  // One cycle of trigger or sample
  task automatic pulse(input logic t, input logic [15:0] d);
    @(posedge core_clk);
    trigIn   <= t;
    smpValid <= !t;
    smpData  <= d;
    @(posedge core_clk);
    trigIn   <= 1'b0;
    smpValid <= 1'b0;
    smpData  <= ~d;
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    end_of_test();
  end

  // Main sequence
  initial begin
    num_errors = 0;
    n_compared = 0;
    arst_n = 1'b0;
    curMag = '0;
    curValid = '0;
    smpValid = 1'b0;
    smpData = '0;
    trigIn = 1'b0;
    void'($urandom(77867));
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    for (c = 0; c < 4; c++) begin
      rdc("range", ad(c, `HRC_OFF_RANGE), `HRC_FS3_UA);
      rdc("auto", ad(c, `HRC_OFF_AUTO), 32'h0);
      rdc("hist", ad(c, `HRC_OFF_HIST), 32'h0);
      rdc("depth", ad(c, `HRC_OFF_DEPTH), 32'(`HRC_RST_DEPTH));
      rdc("offset", ad(c, `HRC_OFF_OFFSET), `HRC_RST_OFFSET);
    end
    wr(8'hfc, $urandom());
    rdc("unmapped", 8'hfc, 32'h0);
    // Manual ranges, corners then random, all channels kept apart
    for (int i = 0; i < 12; i++) begin
      v = (i < 4) ? (i == 0 ? 10 : i == 1 ? 11 : i == 2 ? 1000 : 100001)
                  : $urandom_range(0, 8000000);
      wr(ad(i % 4, `HRC_OFF_RANGE), v);
      mv[i % 4] = v;
      if (i % 4 == 3) begin
        for (c = 0; c < 4; c++) rdc("range", ad(c, `HRC_OFF_RANGE), fs(mv[c]));
      end
    end
    wr(ad(1, `HRC_OFF_RANGE), 32'h8000_0000);
    rdc("min", ad(1, `HRC_OFF_RANGE), `HRC_FS0_UA);
    wr(ad(1, `HRC_OFF_RANGE), 32'hc000_0000);
    rdc("max", ad(1, `HRC_OFF_RANGE), `HRC_FS3_UA);
    // Autoranging over a manual minimum
    wr(ad(0, `HRC_OFF_RANGE), 32'h8000_0000);
    for (c = 0; c < 4; c++) begin
      wr(ad(c, `HRC_OFF_AUTO), 32'h1);
      wr(ad(c, `HRC_OFF_HIST), 32'h1);
      rdc("auto", ad(c, `HRC_OFF_AUTO), 32'h1);
      rdc("hist", ad(c, `HRC_OFF_HIST), 32'h1);
      chk("histEn", 32'h1, chanCfg[c].histEn);
    end
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 0 : $urandom_range(0, 3);
      v = (i == 0) ? 5 : $urandom_range(0, 8000000);
      @(posedge core_clk);
      curMag[c] <= v;
      curValid[c] <= 1'b1;
      @(posedge core_clk);
      curValid[c] <= 1'b0;
      rdc("autorange", ad(c, `HRC_OFF_RANGE), v <= 1000 ? `HRC_FS1_UA : fs(v));
    end
    wr(ad(0, `HRC_OFF_AUTO), 32'h0);
    rdc("manual", ad(0, `HRC_OFF_RANGE), `HRC_FS0_UA);
    // Depth limit against parameter count
    for (int i = 0; i < 5; i++) begin
      wr(`HRC_OFF_CAPCTL, {16'h0, (i == 4) ? 8'hff : 8'((2 << i) - 1), 8'h00});
      wr(ad(1, `HRC_OFF_DEPTH), 32'h000f_ffff);
      rdc("depthmax", ad(1, `HRC_OFF_DEPTH), 32'h80000 >> (i > 3 ? 3 : i));
    end
    wr(ad(1, `HRC_OFF_DEPTH), 32'h0);
    rdc("depthmin", ad(1, `HRC_OFF_DEPTH), 32'h1);
    wr(`HRC_OFF_CAPCTL, 32'h0100);
    wr(ad(2, `HRC_OFF_OFFSET), 32'hffff_0000);
    rdc("offneg", ad(2, `HRC_OFF_OFFSET), 32'hffff_fc01);
    wr(ad(2, `HRC_OFF_OFFSET), 32'h7fff_ffff);
    rdc("offpos", ad(2, `HRC_OFF_OFFSET), `HRC_OFFSET_MAX);
    pulse(1'b1, 16'h0);
    @(posedge core_clk);
    chk("idletrig", 32'h0, capBusy);
    // Captures with positive, negative and zero offset
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 8; i++) s[i] = 16'($urandom());
      wr(ad(0, `HRC_OFF_DEPTH), dp[k]);
      wr(ad(0, `HRC_OFF_OFFSET), of[k]);
      wr(`HRC_OFF_CAPCTL, 32'h0101);
      for (int i = 0; i < np[k]; i++) pulse(1'b0, s[i]);
      chk("capBusy", 32'h1, capBusy);
      pulse(1'b1, 16'h0);
      for (int i = np[k]; i < 8; i++) pulse(1'b0, s[i]);
      for (int i = 0; i < 40 && capDone !== 1'b1; i++) @(posedge core_clk);
      chk("capDone", 32'h1, capDone);
      wr(`HRC_OFF_RDADDR, 32'h0);
      for (int i = 0; i < dp[k]; i++) rdc("record", `HRC_OFF_RDDATA, s[np[k] + of[k] + i]);
    end
    end_of_test();
  end
endmodule
